// ===== src/ccc_check.sv
/*
 * ccc_check: check-condition triggers of a stored-program data channel.
 * Assumes command strobes, operation register bits and adapter status are
 * synchronous to i_clk; one command is decoded per i_cmd_valid pulse.
 */
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module ccc_check (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_cmd_valid,
    input wire ccc_pkg::ccc_cmd_type i_cmd,
    input wire logic [2:0] i_op_s12,
    input wire logic i_count_zero,
    input wire logic i_service_req,
    input wire logic i_ring_fail,
    input wire logic i_adapter_oper,
    input wire logic i_unusual_end,
    input wire logic i_io_loss,
    input wire logic i_reset_start,
    input wire logic i_chan_reset,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_interrupt,
    output logic o_write_trig,
    output logic o_read_trig,
    output logic o_adapter_write,
    output logic o_adapter_read,
    output logic o_wait,
    output logic [2:0] o_asm_ring,
    output logic [1:0] o_char_ring,
    output logic [35:0] o_asm_word
);
    import ccc_pkg::*;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // interface command: sign=0, bit1=1, bit2 don't care pattern 01x
    function automatic logic is_iface(input logic [2:0] s12);
        is_iface = (s12[2:1] == 2'h1);
    endfunction : is_iface
    function automatic logic is_copy(input ccc_cmd_type c);
        is_copy = (c == CCC_CMD_COPY_PROCEED_CMD) || (c == CCC_CMD_COPY_DISCONNECT_CMD);
    endfunction : is_copy

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    ccc_seq_type seq, next_seq;
    logic last_iface, next_last_iface;
    logic last_ctl, next_last_ctl;
    logic seq_chk, next_seq_chk;
    logic ifc_chk, next_ifc_chk;
    logic io_chk, next_io_chk;
    logic uend, next_uend;
    logic in_intr, next_in_intr;
    logic gate_ovr, next_gate_ovr;
    logic [1:0] ring_busy, next_ring_busy;
    logic [1:0] char_ring, next_char_ring;
    logic [2:0] asm_ring, next_asm_ring;
    logic [35:0] asm_word, next_asm_word;
    logic wr_trig, next_wr_trig;
    logic rd_trig, next_rd_trig;
    logic wait_st, next_wait_st;
    logic [31:0] prdata, next_prdata;
    logic pready, next_pready;
    logic pslverr, next_pslverr;
    logic intr, next_intr;
    logic [6:0] check_condition_reg;

    assign check_condition_reg = {3'h0, uend, io_chk, ifc_chk, seq_chk};

    // ------------------------------------------------------------
    // check triggers and sequence tracking
    // ------------------------------------------------------------
    logic gate, clr_all, ccc_cycle, set_seq, set_ifc, iface_now, apb_acc;
    always_comb begin
        next_seq = seq;
        next_last_iface = last_iface;
        next_last_ctl = last_ctl;
        next_seq_chk = seq_chk;
        next_ifc_chk = ifc_chk;
        next_io_chk = io_chk;
        next_uend = uend;
        next_in_intr = in_intr;
        next_ring_busy = ring_busy;
        next_char_ring = char_ring;
        next_asm_ring = asm_ring;
        next_asm_word = asm_word;
        next_wr_trig = wr_trig;
        next_rd_trig = rd_trig;
        next_wait_st = wait_st;
        gate = !in_intr || gate_ovr;
        clr_all = i_reset_start || (i_cmd_valid && (i_cmd == CCC_CMD_LIP || i_cmd == CCC_CMD_LEAVE_INTERRUPT_TRANSFER_CMD));
        iface_now = i_cmd_valid && is_iface(i_op_s12);
        // TCH and interface commands block the counter cycle; others, TDC and TCM included, request it
        ccc_cycle = i_cmd_valid && i_cmd != CCC_CMD_TCH && !iface_now;
        set_seq = 1'b0;
        set_ifc = 1'b0;
        if (i_cmd_valid && is_copy(i_cmd) && seq == CCC_ST_IDLE) begin
            set_seq = 1'b1;
        end
        if (iface_now && last_iface && !last_ctl) begin
            set_seq = 1'b1;
        end
        if (ccc_cycle && !is_copy(i_cmd) && ((seq inside {CCC_ST_COPY, CCC_ST_SENSE} && i_cmd != CCC_CMD_TDC)
            || (seq inside {CCC_ST_PREP_W, CCC_ST_PREP_R} && i_cmd == CCC_CMD_WTR))) begin
            set_seq = 1'b1; // a wait while prepared would hang the adapter
        end
        if (iface_now && !i_adapter_oper) begin
            set_ifc = 1'b1;
        end
        // request arriving while ring still busy is an overrun
        if ((i_service_req && ring_busy != 2'h0) || i_ring_fail) begin
            set_ifc = 1'b1;
        end
        if (i_service_req) begin
            next_ring_busy = 2'h3;
            next_char_ring = char_ring + 2'h1;
        end else if (ring_busy != 2'h0) begin
            next_ring_busy = ring_busy - 2'h1;
        end
        // sequence state tracking
        if (i_cmd_valid) begin
            next_wait_st = 1'b0;
            if (iface_now) begin
                next_last_iface = 1'b1;
                next_last_ctl = (i_cmd == CCC_CMD_CTL);
            end else if (!(i_cmd inside {CCC_CMD_TCH, CCC_CMD_TDC, CCC_CMD_COPY_PROCEED_CMD})) begin
                next_last_iface = 1'b0;
                next_last_ctl = 1'b0;
            end
            unique case (i_cmd)
                CCC_CMD_CONTROL_AND_WRITE_CMD: next_seq = CCC_ST_PREP_W;
                CCC_CMD_CONTROL_AND_READ_CMD: next_seq = CCC_ST_PREP_R;
                CCC_CMD_SNS: next_seq = CCC_ST_SENSE;
                CCC_CMD_CTL: next_seq = CCC_ST_IDLE;
                CCC_CMD_COPY_PROCEED_CMD, CCC_CMD_COPY_DISCONNECT_CMD: begin
                    if (seq == CCC_ST_PREP_W) begin
                        next_wr_trig = 1'b1;
                    end
                    if (seq == CCC_ST_PREP_R || seq == CCC_ST_SENSE) begin
                        next_rd_trig = 1'b1;
                    end
                    next_seq = (i_cmd == CCC_CMD_COPY_DISCONNECT_CMD) ? CCC_ST_IDLE : CCC_ST_COPY;
                    if (i_cmd == CCC_CMD_COPY_DISCONNECT_CMD) begin
                        next_wr_trig = 1'b0;
                        next_rd_trig = 1'b0;
                    end
                end
                CCC_CMD_ICC: begin
                    if (i_count_zero) begin
                        next_asm_word[CCC_ASM_W-1:CCC_ASM_LO] = check_condition_reg;
                    end
                end
                default: begin
                    if (ccc_cycle && seq inside {CCC_ST_PREP_W, CCC_ST_PREP_R}) next_seq = CCC_ST_IDLE;
                end
            endcase
        end
        // triggers record only through the check condition gate
        if (gate) begin
            if (set_seq) next_seq_chk = 1'b1;
            if (set_ifc) next_ifc_chk = 1'b1;
            if (i_io_loss) next_io_chk = 1'b1;
            if (i_unusual_end) next_uend = 1'b1;
            if (set_seq || set_ifc || i_io_loss || i_unusual_end) next_in_intr = 1'b1;
        end
        // software write-1-clear of check_condition_reg; a new set wins
        if (apb_acc && i_pwrite && i_paddr == CCC_OFF_STATUS) begin
            if (i_pwdata[CCC_BIT_SEQ] && !(gate && set_seq)) next_seq_chk = 1'b0;
            if (i_pwdata[CCC_BIT_IFC] && !(gate && set_ifc)) next_ifc_chk = 1'b0;
            if (i_pwdata[CCC_BIT_IOC] && !(gate && i_io_loss)) next_io_chk = 1'b0;
            if (i_pwdata[CCC_BIT_UEND] && !(gate && i_unusual_end)) next_uend = 1'b0;
        end
        if (clr_all) begin
            next_seq_chk = 1'b0;
            next_ifc_chk = 1'b0;
            next_io_chk = 1'b0;
            next_uend = 1'b0;
            next_in_intr = 1'b0;
        end
    end

    // one interrupt pulse per entry into the interrupt program
    always_comb begin
        next_intr = next_in_intr && !in_intr;
    end

    // ------------------------------------------------------------
    // apb slave: zero wait state, unmapped address gives pslverr
    // ------------------------------------------------------------
    assign apb_acc = i_psel && i_penable && pready;
    always_comb begin
        next_gate_ovr = gate_ovr;
        next_prdata = prdata;
        next_pslverr = 1'b0;
        next_pready = 1'b0;
        if (i_psel && !i_penable) begin
            next_pready = 1'b1;
            next_prdata = 32'h00000000;
            unique case (i_paddr)
                CCC_OFF_STATUS: next_prdata = {25'h0000000, check_condition_reg};
                CCC_OFF_CTRL: next_prdata = {31'h00000000, gate_ovr};
                CCC_OFF_ASM: next_prdata = asm_word[31:0];
                CCC_OFF_STATE: next_prdata = {27'h0000000, wait_st, seq[2:0], in_intr} & 32'h0000001F;
                default: next_pslverr = 1'b1;
            endcase
        end else if (i_psel && i_penable && !pready) begin
            next_pready = 1'b1;
        end
        if (apb_acc && i_pwrite && i_paddr == CCC_OFF_CTRL) begin
            next_gate_ovr = i_pwdata[0];
        end
    end

    // ------------------------------------------------------------
    // registers: synchronous reset, clock enable freezes all
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_nrst || (i_ce && i_chan_reset)) begin
            seq <= CCC_ST_IDLE;
            last_iface <= 1'b0;
            last_ctl <= 1'b0;
            seq_chk <= 1'b0;
            ifc_chk <= 1'b0;
            io_chk <= 1'b0;
            uend <= 1'b0;
            in_intr <= 1'b0;
            gate_ovr <= 1'b0;
            ring_busy <= 2'h0;
            char_ring <= CCC_CRING_RST;
            asm_ring <= CCC_ARING_RST;
            asm_word <= 36'h000000000;
            wr_trig <= 1'b0;
            rd_trig <= 1'b0;
            wait_st <= 1'b1;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            intr <= 1'b0;
        end else if (i_ce) begin
            seq <= next_seq;
            last_iface <= next_last_iface;
            last_ctl <= next_last_ctl;
            seq_chk <= next_seq_chk;
            ifc_chk <= next_ifc_chk;
            io_chk <= next_io_chk;
            uend <= next_uend;
            in_intr <= next_in_intr;
            gate_ovr <= next_gate_ovr;
            ring_busy <= next_ring_busy;
            char_ring <= next_char_ring;
            asm_ring <= next_asm_ring;
            asm_word <= next_asm_word;
            wr_trig <= next_wr_trig;
            rd_trig <= next_rd_trig;
            wait_st <= next_wait_st;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            intr <= next_intr;
        end
    end

    // outputs straight from flip-flops
    assign o_prdata = prdata;
    assign o_pready = pready;
    assign o_pslverr = pslverr;
    assign o_interrupt = intr;
    assign o_write_trig = wr_trig;
    assign o_read_trig = rd_trig;
    assign o_adapter_write = wr_trig;
    assign o_adapter_read = rd_trig;
    assign o_wait = wait_st;
    assign o_asm_ring = asm_ring;
    assign o_char_ring = char_ring;
    assign o_asm_word = asm_word;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst || !i_ce || i_chan_reset);

    copy_unprepared_a: assert property ((i_cmd_valid && is_copy(i_cmd) && seq == CCC_ST_IDLE && !in_intr
        && !clr_all) |=> seq_chk) else $error("unprepared copy missed");
    iface_pair_a: assert property ((iface_now && last_iface && !last_ctl && !in_intr && !clr_all)
        |=> seq_chk) else $error("back to back interface missed");
    xfer_no_seq_a: assert property ((i_cmd_valid && i_cmd == CCC_CMD_TCH && !seq_chk && seq == CCC_ST_COPY
        && !iface_now) |=> !seq_chk) else $error("transfer raised sequence check");
    gate_block_a: assert property ((in_intr && !gate_ovr && !seq_chk && !clr_all) |=> !seq_chk)
        else $error("check recorded in interrupt");
    copy_write_a: assert property ((i_cmd_valid && i_cmd == CCC_CMD_COPY_PROCEED_CMD && seq == CCC_ST_PREP_W)
        |=> o_adapter_write && seq == CCC_ST_COPY) else $error("copy did not start write");
    overrun_a: assert property ((i_service_req && ring_busy != 2'h0 && !in_intr && !clr_all) |=> ifc_chk)
        else $error("overrun missed");
    single_intr_a: assert property (o_interrupt |=> !o_interrupt) else $error("double interrupt");
    not_oper_a: assert property ((iface_now && !i_adapter_oper && !in_intr && !clr_all) |=> ifc_chk && o_interrupt)
        else $error("not operational missed");
    leave_clr_a: assert property ((i_cmd_valid && i_cmd == CCC_CMD_LIP) |=> check_condition_reg == CCC_SMS_RST)
        else $error("leave did not clear");
    icc_copy_a: assert property ((i_cmd_valid && i_cmd == CCC_CMD_ICC && i_count_zero)
        |=> asm_word[35:29] == $past(check_condition_reg)) else $error("icc copy wrong");

    seq_cov_c: cover property (i_cmd_valid && i_cmd == CCC_CMD_CONTROL_AND_WRITE_CMD ##[1:8] i_cmd_valid && i_cmd == CCC_CMD_COPY_DISCONNECT_CMD);
    seqchk_cov_c: cover property (o_interrupt && seq_chk);
    ifc_cov_c: cover property (o_interrupt && ifc_chk);
    leave_cov_c: cover property (in_intr ##[1:20] !in_intr);
endmodule : ccc_check
`default_nettype wire

// ===== src/ccc_pkg.sv
/*
 * ccc_pkg: constants and types for the channel check-condition unit.
 * Assumes a 200 MHz channel clock and APB register access.
 */
package ccc_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // ------------------------------------------------------------
    localparam logic [7:0] CCC_OFF_STATUS = 8'h00; // check_condition_reg, read, write-1-clear
    localparam logic [7:0] CCC_OFF_CTRL = 8'h04;   // control: bit0 gate override
    localparam logic [7:0] CCC_OFF_ASM = 8'h08;    // assembly word image, read only
    localparam logic [7:0] CCC_OFF_STATE = 8'h0C;  // sequence state, read only
    // ------------------------------------------------------------
    // check_condition_reg fields
    // ------------------------------------------------------------
    localparam int CCC_BIT_SEQ = 0;   // sequence check
    localparam int CCC_BIT_IFC = 1;   // interface check
    localparam int CCC_BIT_IOC = 2;   // io check
    localparam int CCC_BIT_UEND = 3;  // unusual end seen
    localparam int CCC_ASM_LO = 29;   // assembly bits 29..35 hold the checks
    localparam int CCC_ASM_W = 36;
    localparam int CCC_SMS_W = 7;
    localparam logic [6:0] CCC_SMS_RST = 7'h00;
    localparam logic [2:0] CCC_ARING_RST = 3'h6;  // assembly ring position after reset
    localparam logic [1:0] CCC_CRING_RST = 2'h3;  // character ring position 4 (0-based 3)
    // ------------------------------------------------------------
    // command codes presented on the operation-register port
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        CCC_CMD_NONE, CCC_CMD_CTL, CCC_CMD_CONTROL_AND_WRITE_CMD, CCC_CMD_CONTROL_AND_READ_CMD, CCC_CMD_SNS,
        CCC_CMD_COPY_PROCEED_CMD, CCC_CMD_COPY_DISCONNECT_CMD, CCC_CMD_TCH, CCC_CMD_TDC, CCC_CMD_TCM,
        CCC_CMD_WTR, CCC_CMD_LIP, CCC_CMD_LEAVE_INTERRUPT_TRANSFER_CMD, CCC_CMD_ICC, CCC_CMD_OTHER
    } ccc_cmd_type;
    // sequence states
    typedef enum logic [2:0] {
        CCC_ST_IDLE, CCC_ST_PREP_W, CCC_ST_PREP_R, CCC_ST_SENSE, CCC_ST_COPY
    } ccc_seq_type;
endpackage : ccc_pkg

// ===== tb/ccc_adapter_model.sv
/*
 * ccc_adapter_model: behavioural I-O adapter on the far side of the channel.
 * Assumes the bench sets the request gap, overrun unusual-end and operational level.
 */
`timescale 1ns/1ps
`default_nettype none
module ccc_adapter_model (
    input wire logic i_clk,
    input wire logic i_write,
    input wire logic i_read,
    input wire logic [3:0] i_gap,
    input wire logic i_uend_en,
    input wire logic i_oper_en,
    output logic o_service_req,
    output logic o_unusual_end,
    output logic o_oper
);
    logic [3:0] cnt;
    logic seen;
    // start quiet
    initial begin
        cnt = 4'h0;
        seen = 1'b0;
        o_service_req = 1'b0;
        o_unusual_end = 1'b0;
    end
    // ------------------------------------------------------------
    // service requests
    // ------------------------------------------------------------
    // one request every gap cycles, only while the channel signals write or read
    always @(posedge i_clk) begin
        o_service_req <= 1'b0;
        o_unusual_end <= 1'b0;
        cnt <= (cnt == 4'hF) ? cnt : cnt + 4'h1;
        if (!(i_write || i_read)) begin
            seen <= 1'b0;
        end else if (cnt >= i_gap) begin
            o_service_req <= 1'b1;
            cnt <= 4'h1;
            seen <= 1'b1;
            o_unusual_end <= i_uend_en && seen && (i_gap < 4'h4);
        end
    end
    // operational level as commanded
    assign o_oper = i_oper_en;
endmodule : ccc_adapter_model
`default_nettype wire

// ===== tb/tb_top.sv
/*
 * tb_top: self-checking bench of the channel check-condition unit.
 * Assumes ccc_pkg, ccc_check and the adapter model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ccc_pkg::*;
    logic i_clk, i_nrst, i_cmd_valid, i_count_zero, i_ring_fail, i_reset_start, i_chan_reset;
    logic i_psel, i_penable, i_pwrite, o_pready, o_pslverr, o_interrupt, o_wait;
    logic o_write_trig, o_read_trig, o_adapter_write, o_adapter_read, svc, uend, oper, uend_en, oper_en;
    ccc_cmd_type i_cmd;
    logic [2:0] i_op_s12, o_asm_ring;
    logic [1:0] o_char_ring;
    logic [3:0] gap;
    logic [7:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata;
    logic [35:0] o_asm_word;
    logic [64:0] exp_q[$], ent;
    int num_errors = 0, check_count = 0, irq_count = 0, cycles = 0, irq0;
    ccc_cmd_type ifc[4] = '{CCC_CMD_CTL, CCC_CMD_CONTROL_AND_WRITE_CMD, CCC_CMD_CONTROL_AND_READ_CMD, CCC_CMD_SNS};

    ccc_check dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(1'b1), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
        .i_op_s12(i_op_s12), .i_count_zero(i_count_zero), .i_service_req(svc), .i_ring_fail(i_ring_fail),
        .i_adapter_oper(oper), .i_unusual_end(uend), .i_io_loss(1'b0), .i_reset_start(i_reset_start),
        .i_chan_reset(i_chan_reset), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
        .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .o_interrupt(o_interrupt), .o_write_trig(o_write_trig),
        .o_read_trig(o_read_trig), .o_adapter_write(o_adapter_write), .o_adapter_read(o_adapter_read),
        .o_wait(o_wait), .o_asm_ring(o_asm_ring), .o_char_ring(o_char_ring), .o_asm_word(o_asm_word));
    ccc_adapter_model adapter (.i_clk(i_clk), .i_write(o_adapter_write), .i_read(o_adapter_read),
        .i_gap(gap), .i_uend_en(uend_en), .i_oper_en(oper_en), .o_service_req(svc),
        .o_unusual_end(uend), .o_oper(oper));
    // ------------------------------------------------------------
    // clock, shared tasks
    // ------------------------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    // compare and count
    task automatic check(input string nm, input logic [35:0] seen, input logic [35:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // verdict and end of run
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report
    // one command strobe, op bits random outside the decoded field
    task automatic cmd(input ccc_cmd_type c);
        int r;
        r = $urandom % 3;
        i_cmd_valid <= 1'b1;
        i_cmd <= c;
        i_op_s12 <= {(c inside {ifc}) ? 2'b01 : 2'(r == 0 ? 0 : r + 1), 1'($urandom)};
        i_count_zero <= (c == CCC_CMD_ICC);
        @(posedge i_clk);
        i_cmd_valid <= 1'b0;
        i_cmd <= CCC_CMD_NONE;
        @(posedge i_clk);
    endtask : cmd
    // apb transfer; the expected answer goes to the queue
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                       input logic [31:0] e, input logic er);
        exp_q.push_back({er, m, e});
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        @(posedge i_clk);
        while (o_pready !== 1'b1) @(posedge i_clk);
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_clk);
    endtask : apb
    // status read under a mask
    task automatic st(input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, CCC_OFF_STATUS, 32'h0, m, e, 1'b0);
    endtask : st
    // ring failure pulse
    task automatic ring_pulse();
        i_ring_fail <= 1'b1;
        @(posedge i_clk);
        i_ring_fail <= 1'b0;
        @(posedge i_clk);
    endtask : ring_pulse
    // full channel reset and its resting state
    task automatic rst();
        i_chan_reset <= 1'b1;
        @(posedge i_clk);
        i_chan_reset <= 1'b0;
        @(posedge i_clk);
        check("reset state", 36'({o_wait, o_asm_ring, o_char_ring, o_write_trig, o_read_trig}),
              36'({1'b1, CCC_ARING_RST, CCC_CRING_RST, 2'b00}));
        check("asm word", o_asm_word, 36'h0);
    endtask : rst
    // one sequence, run with control-write and again with control-read
    task automatic run_seq(input ccc_cmd_type a, b, c, d, input logic bad);
        ccc_cmd_type s[4];
        int base;
        for (int p = 0; p < 2; p++) begin
            rst();
            base = irq_count;
            s = '{a, b, c, d};
            foreach (s[k]) begin
                if (p == 1 && s[k] == CCC_CMD_CONTROL_AND_WRITE_CMD) s[k] = CCC_CMD_CONTROL_AND_READ_CMD;
                if (s[k] != CCC_CMD_NONE) cmd(s[k]);
            end
            st(32'hF, {31'h0, bad});
            check("irq count", 36'(irq_count - base), 36'(bad));
        end
    endtask : run_seq
    // ------------------------------------------------------------
    // monitor: interrupts, apb answers, timeout
    // ------------------------------------------------------------
    always @(posedge i_clk) begin
        cycles++;
        if (o_interrupt === 1'b1) irq_count++;
        if (i_psel && i_penable && o_pready === 1'b1 && exp_q.size() > 0) begin
            ent = exp_q.pop_front();
            check("prdata", 36'(o_prdata & ent[63:32]), 36'(ent[31:0]));
            check("pslverr", 36'(o_pslverr), 36'(ent[64]));
        end
        if (cycles == 20000) begin
            num_errors++;
            final_report();
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {i_nrst, i_cmd_valid, i_count_zero, i_ring_fail, i_reset_start, i_chan_reset} = '0;
        {i_psel, i_penable, i_pwrite, i_op_s12, i_paddr, i_pwdata, uend_en} = '0;
        i_cmd = CCC_CMD_NONE;
        gap = 4'h6;
        oper_en = 1'b1;
        void'($urandom(32'h0824));
        repeat (2) @(posedge i_clk);
        i_nrst <= 1'b1;
        @(posedge i_clk);
        run_seq(CCC_CMD_CTL, CCC_CMD_CTL, CCC_CMD_NONE, CCC_CMD_NONE, 1'b0);
        run_seq(CCC_CMD_CTL, CCC_CMD_CONTROL_AND_WRITE_CMD, CCC_CMD_COPY_DISCONNECT_CMD, CCC_CMD_NONE, 1'b0);
        run_seq(CCC_CMD_CONTROL_AND_WRITE_CMD, CCC_CMD_COPY_PROCEED_CMD, CCC_CMD_TCH, CCC_CMD_COPY_DISCONNECT_CMD, 1'b0);
        run_seq(CCC_CMD_CONTROL_AND_WRITE_CMD, CCC_CMD_COPY_PROCEED_CMD, CCC_CMD_TDC, CCC_CMD_COPY_DISCONNECT_CMD, 1'b0);
        run_seq(CCC_CMD_CONTROL_AND_WRITE_CMD, CCC_CMD_TCM, CCC_CMD_NONE, CCC_CMD_NONE, 1'b0);
        run_seq(CCC_CMD_CONTROL_AND_WRITE_CMD, CCC_CMD_TCH, CCC_CMD_COPY_PROCEED_CMD, CCC_CMD_COPY_DISCONNECT_CMD, 1'b0);
        run_seq(CCC_CMD_SNS, CCC_CMD_COPY_PROCEED_CMD, CCC_CMD_COPY_DISCONNECT_CMD, CCC_CMD_NONE, 1'b0);
        run_seq(CCC_CMD_CTL, CCC_CMD_COPY_DISCONNECT_CMD, CCC_CMD_NONE, CCC_CMD_NONE, 1'b1);
        run_seq(CCC_CMD_CONTROL_AND_WRITE_CMD, CCC_CMD_CTL, CCC_CMD_NONE, CCC_CMD_NONE, 1'b1);
        run_seq(CCC_CMD_CONTROL_AND_WRITE_CMD, CCC_CMD_COPY_PROCEED_CMD, CCC_CMD_CTL, CCC_CMD_NONE, 1'b1);
        run_seq(CCC_CMD_SNS, CCC_CMD_CTL, CCC_CMD_NONE, CCC_CMD_NONE, 1'b1);
        run_seq(CCC_CMD_CONTROL_AND_WRITE_CMD, CCC_CMD_COPY_PROCEED_CMD, CCC_CMD_TCM, CCC_CMD_NONE, 1'b1);
        run_seq(CCC_CMD_CONTROL_AND_WRITE_CMD, CCC_CMD_WTR, CCC_CMD_NONE, CCC_CMD_NONE, 1'b1);
        run_seq(CCC_CMD_CONTROL_AND_WRITE_CMD, CCC_CMD_COPY_PROCEED_CMD, CCC_CMD_WTR, CCC_CMD_NONE, 1'b1);
        run_seq(CCC_CMD_CONTROL_AND_WRITE_CMD, CCC_CMD_TCM, CCC_CMD_COPY_DISCONNECT_CMD, CCC_CMD_NONE, 1'b1);
        // prepare, copy, disconnect in both directions
        for (int p = 0; p < 2; p++) begin
            rst();
            cmd(p ? CCC_CMD_CONTROL_AND_READ_CMD : CCC_CMD_CONTROL_AND_WRITE_CMD);
            cmd(CCC_CMD_COPY_PROCEED_CMD);
            check("copy trig", 36'({o_write_trig, o_read_trig, o_adapter_write, o_adapter_read, o_wait}),
                  36'({p == 0, p == 1, p == 0, p == 1, 1'b0}));
            cmd(CCC_CMD_COPY_DISCONNECT_CMD);
            check("trig off", 36'({o_write_trig, o_read_trig}), 36'h0);
        end
        // checks held off in the interrupt program, image, sticky, clears
        rst();
        cmd(CCC_CMD_CTL);
        cmd(CCC_CMD_COPY_DISCONNECT_CMD);
        ring_pulse();
        st(32'h3, 32'h1);
        cmd(CCC_CMD_ICC);
        apb(1'b0, CCC_OFF_ASM, 32'h0, 32'hE0000000, 32'h20000000, 1'b0);
        apb(1'b1, CCC_OFF_STATUS, 32'h0, 32'h0, 32'h0, 1'b0);
        st(32'hF, 32'h1);
        apb(1'b0, 8'h10, 32'h0, 32'h0, 32'h0, 1'b1);
        for (int k = 0; k < 3; k++) begin
            if (k == 2) begin
                i_reset_start <= 1'b1;
                @(posedge i_clk);
                i_reset_start <= 1'b0;
                @(posedge i_clk);
            end else begin
                cmd(k ? CCC_CMD_LEAVE_INTERRUPT_TRANSFER_CMD : CCC_CMD_LIP);
            end
            st(32'hF, 32'h0);
            irq0 = irq_count;
            cmd(CCC_CMD_CTL);
            cmd(CCC_CMD_COPY_DISCONNECT_CMD);
            st(32'hF, 32'h1);
            check("irq again", 36'(irq_count - irq0), 36'h1);
        end
        // overrun with unusual end from the adapter
        rst();
        uend_en <= 1'b1;
        gap <= 4'(1 + $urandom % 3);
        irq0 = irq_count;
        cmd(CCC_CMD_CONTROL_AND_WRITE_CMD);
        cmd(CCC_CMD_COPY_PROCEED_CMD);
        repeat (12) @(posedge i_clk);
        st(32'h2, 32'h2);
        check("one irq", 36'(irq_count - irq0), 36'h1);
        uend_en <= 1'b0;
        gap <= 4'h6;
        // ring failure
        rst();
        irq0 = irq_count;
        ring_pulse();
        st(32'h2, 32'h2);
        check("ring irq", 36'(irq_count - irq0), 36'h1);
        // interface commands with no operational adapter
        oper_en <= 1'b0;
        foreach (ifc[k]) begin
            rst();
            cmd(ifc[k]);
            st(32'h2, 32'h2);
        end
        oper_en <= 1'b1;
        final_report();
    end
endmodule : tb_top
`default_nettype wire
